// ### design/sesg_pkg.sv
/*
  Constants for the standard event status group: bit positions, reset
  values and the completion-marker state encoding shared by the design.
  Assumes a command decoder upstream that turns remote common commands
  into single-cycle strobes with an 8-bit parameter where one is needed.
*/
// Function
// - set bit 0 once all commands through the completion marker executed; bits 1,6 zero
// - set bit 2 on empty-buffer read, unread reply overrun, or both buffers full
// - set bit 3 on self-test or calibration failure
// - set bit 4 on execution error in minus-two-hundred range
// - set bit 5 on command syntax error in minus-one-hundred range
// - set bit 7 when power cycled since last read or clear
// - summary bit is OR of event bits gated by enable bits
// - enable mask written as binary-weighted value; controller must supply it
// - queries answer with binary-weighted sum of set bits
// - event register read-only, latches events, read returns then clears
// - set bits stay set until read or clear-status
// - clear-status zeroes event bits, keeps enable mask
// - clear-status also clears operation, questionable, status byte and error queue
// - clear-status after message terminator also empties output queue and message-available
// - status preset leaves status byte bits unchanged
// - completion marker defers bit 0 until earlier and parallel operations finish
package sesg_pkg;
  localparam int EVENT_WIDTH = 8;
  localparam int BIT_OPC = 0;
  localparam int BIT_UNUSED1 = 1;
  localparam int BIT_QUERY = 2;
  localparam int BIT_DEVICE = 3;
  localparam int BIT_EXEC = 4;
  localparam int BIT_CMD = 5;
  localparam int BIT_UNUSED6 = 6;
  localparam int BIT_PON = 7;
  localparam logic [7:0] USED_MASK = 8'hBD;
  localparam logic [7:0] LATCH_RESET = 8'h80;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] READ_RESET = 8'h00;
  typedef enum logic [1:0] {
    SESG_OPC_IDLE = 2'b00,
    SESG_OPC_WAIT = 2'b01
  } sesg_opc_type;
endpackage

// ### design/sesg_top.sv
/*
  Standard event status group: event latch, enable mask, summary bit,
  and the clear-status side effects on the rest of the status system.
  Assumes command strobes arrive synchronous to clk, one cycle each, and
  that the controller always supplies a parameter with an enable write.
*/
`timescale 1ns/1ps
module sesg_top #(
  parameter int EVENT_WIDTH = sesg_pkg::EVENT_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opc_cmd,
  input wire logic ops_pending,
  input wire logic query_empty_read,
  input wire logic query_interrupted,
  input wire logic query_deadlock,
  input wire logic selftest_fail,
  input wire logic cal_fail,
  input wire logic exec_error,
  input wire logic cmd_error,
  input wire logic enable_write,
  input wire logic [7:0] enable_data,
  input wire logic latch_read,
  input wire logic enable_read,
  input wire logic clear_status,
  input wire logic after_terminator,
  input wire logic status_preset,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic summary,
  output logic clear_others,
  output logic clear_output_queue
);
  logic [7:0] latch_reg, latch_next;
  logic [7:0] enable_reg, enable_next;
  logic [7:0] read_data_reg, read_data_next;
  logic read_valid_reg, read_valid_next;
  logic summary_reg, summary_next;
  logic clr_oth_reg, clr_oth_next;
  logic clr_oq_reg, clr_oq_next;
  sesg_pkg::sesg_opc_type opc_reg, opc_next;
  logic opc_done;
  logic [7:0] set_vec;

  // latch and answer path are built for eight event bits only
  if (EVENT_WIDTH != sesg_pkg::EVENT_WIDTH) begin : g_width_check
    $error("sesg_top supports only the eight-bit event width");
  end

  // summary decode, shared by the normal and the preset path
  function automatic logic summary_of(input logic [7:0] lat, input logic [7:0] ena);
    return |(lat & ena);
  endfunction

  // completion marker waits for earlier work while later commands proceed
  always_comb begin
    opc_next = opc_reg;
    opc_done = 1'b0;
    case (opc_reg)
      sesg_pkg::SESG_OPC_IDLE: begin
        if (opc_cmd && !ops_pending) begin
          opc_done = 1'b1;
        end else if (opc_cmd) begin
          opc_next = sesg_pkg::SESG_OPC_WAIT;
        end
      end
      sesg_pkg::SESG_OPC_WAIT: begin
        if (!ops_pending) begin
          opc_done = 1'b1;
          opc_next = sesg_pkg::SESG_OPC_IDLE;
        end
      end
      default: opc_next = sesg_pkg::SESG_OPC_IDLE;
    endcase
    // clear-status discards a pending marker, else it would set bit 0 later
    if (clear_status) begin
      opc_next = sesg_pkg::SESG_OPC_IDLE;
    end
  end

  // event set pulses gathered into one vector
  always_comb begin
    set_vec = 8'h00;
    set_vec[sesg_pkg::BIT_OPC] = opc_done;
    set_vec[sesg_pkg::BIT_QUERY] = query_empty_read | query_interrupted | query_deadlock;
    set_vec[sesg_pkg::BIT_DEVICE] = selftest_fail | cal_fail;
    set_vec[sesg_pkg::BIT_EXEC] = exec_error;
    set_vec[sesg_pkg::BIT_CMD] = cmd_error;
  end

  // latch, mask and answers; a set in the clearing cycle survives
  always_comb begin
    latch_next = latch_reg;
    if (latch_read || clear_status) begin
      latch_next = 8'h00;
    end
    latch_next = (latch_next | set_vec) & sesg_pkg::USED_MASK;
    enable_next = enable_reg;
    if (enable_write) begin
      enable_next = enable_data;
    end
    read_valid_next = latch_read | enable_read;
    read_data_next = read_data_reg;
    if (latch_read) begin
      read_data_next = latch_reg;
    end else if (enable_read) begin
      read_data_next = enable_reg;
    end
    // registered copy, tracks latch_reg in step; no combinational output
    summary_next = summary_of(latch_next, enable_next);
    clr_oth_next = clear_status;
    clr_oq_next = clear_status & after_terminator;
    // status preset touches nothing here, status byte bits stay put
    if (status_preset) begin
      summary_next = summary_of(latch_next, enable_next);
    end
  end

  // power-on bit comes from reset itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= sesg_pkg::LATCH_RESET;
      enable_reg <= sesg_pkg::ENABLE_RESET;
      read_data_reg <= sesg_pkg::READ_RESET;
      read_valid_reg <= 1'b0;
      summary_reg <= 1'b0;
      clr_oth_reg <= 1'b0;
      clr_oq_reg <= 1'b0;
      opc_reg <= sesg_pkg::SESG_OPC_IDLE;
    end else begin
      latch_reg <= latch_next;
      enable_reg <= enable_next;
      read_data_reg <= read_data_next;
      read_valid_reg <= read_valid_next;
      summary_reg <= summary_next;
      clr_oth_reg <= clr_oth_next;
      clr_oq_reg <= clr_oq_next;
      opc_reg <= opc_next;
    end
  end

  assign read_data = read_data_reg;
  assign read_valid = read_valid_reg;
  assign summary = summary_reg;
  assign clear_others = clr_oth_reg;
  assign clear_output_queue = clr_oq_reg;

  // unused bits never seen set
  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
    latch_reg[1] == 1'b0 && latch_reg[6] == 1'b0)
    else $error("unused event bit set");

  // marker with nothing pending completes at once
  a_opc_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (opc_cmd && !ops_pending && opc_reg == sesg_pkg::SESG_OPC_IDLE) |=> latch_reg[0])
    else $error("completion bit not set");

  // any of the three query faults lands in bit 2
  a_query_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (query_empty_read || query_interrupted || query_deadlock) |=> latch_reg[2])
    else $error("query error not latched");

  // self-test or calibration failure
  a_device_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (selftest_fail || cal_fail) |=> latch_reg[3])
    else $error("device error not latched");

  // execution error
  a_exec_sets: assert property (@(posedge clk) disable iff (!rst_n)
    exec_error |=> latch_reg[4])
    else $error("execution error not latched");

  // syntax error
  a_cmd_sets: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_error |=> latch_reg[5])
    else $error("command error not latched");

  // power-on bit survives until read or clear
  a_pon_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_reg[7] && !latch_read && !clear_status) |=> latch_reg[7])
    else $error("power-on bit lost");

  // only a power cycle raises bit 7 again
  a_pon_only_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !latch_reg[7] |=> !latch_reg[7])
    else $error("power-on bit set without reset");

  // summary is the enabled OR of the latch at all times
  a_summary_level: assert property (@(posedge clk) disable iff (!rst_n)
    summary_reg == |(latch_reg & enable_reg))
    else $error("summary mismatch");

  // mask takes the written value
  a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    enable_write |=> enable_reg == $past(enable_data))
    else $error("mask write lost");

  // mask query answers the mask
  a_mask_query: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_read && !latch_read) |=> read_valid_reg && read_data_reg == $past(enable_reg))
    else $error("mask read data wrong");

  // latch query answers the latch
  a_read_returns: assert property (@(posedge clk) disable iff (!rst_n)
    latch_read |=> read_valid_reg && read_data_reg == $past(latch_reg))
    else $error("latch read data wrong");

  // no answer without a query
  a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (!latch_read && !enable_read) |=> !read_valid_reg)
    else $error("answer without query");

  // answer data stands until the next query
  a_data_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (!latch_read && !enable_read) |=> read_data_reg == $past(read_data_reg))
    else $error("answer data moved");

  // latch query wins over a coinciding mask query
  a_latch_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_read && enable_read) |=> read_data_reg == $past(latch_reg))
    else $error("mask answered over latch");

  // a read with no event in flight leaves the latch empty
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_read && set_vec == 8'h00) |=> latch_reg == 8'h00)
    else $error("read did not clear");

  // reading the latch never touches the mask
  a_read_keeps_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_read && !enable_write) |=> enable_reg == $past(enable_reg))
    else $error("read changed enable");

  // no bit drops without read or clear
  a_bits_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!latch_read && !clear_status) |=> (latch_reg & $past(latch_reg)) == $past(latch_reg))
    else $error("event bit lost");

  // clear-status empties the latch
  a_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
    (clear_status && set_vec == 8'h00) |=> latch_reg == 8'h00)
    else $error("clear left event bits");

  // clear-status keeps the mask
  a_clear_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (clear_status && !enable_write) |=> enable_reg == $past(enable_reg))
    else $error("clear changed enable");

  // clear-status reaches the rest of the status system
  a_clear_others: assert property (@(posedge clk) disable iff (!rst_n)
    clear_status |=> clear_others)
    else $error("others not cleared");

  // no stray clear of the rest of the status system
  a_others_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !clear_status |=> !clear_others)
    else $error("stray clear of others");

  // clear after terminator also empties the output queue
  a_clear_oq: assert property (@(posedge clk) disable iff (!rst_n)
    (clear_status && after_terminator) |=> clear_output_queue && clear_others)
    else $error("clear side effect missing");

  // output queue kept unless clear follows a terminator
  a_outq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !(clear_status && after_terminator) |=> !clear_output_queue)
    else $error("stray output queue clear");

  // status preset alone leaves the summary where it was
  a_preset_still: assert property (@(posedge clk) disable iff (!rst_n)
    (status_preset && set_vec == 8'h00 && !latch_read && !clear_status && !enable_write)
    |=> summary_reg == $past(summary_reg))
    else $error("preset moved summary");

  // nothing reaches the summary through an empty mask
  a_mask_gates: assert property (@(posedge clk) disable iff (!rst_n)
    enable_reg == 8'h00 |-> !summary_reg)
    else $error("summary through empty mask");

  // no completion while earlier work runs
  a_opc_defer: assert property (@(posedge clk) disable iff (!rst_n)
    (opc_reg == sesg_pkg::SESG_OPC_WAIT && ops_pending) |-> !opc_done)
    else $error("completion set early");

  // marker with pending work parks in the wait state
  a_opc_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (opc_cmd && ops_pending && opc_reg == sesg_pkg::SESG_OPC_IDLE && !clear_status)
    |=> opc_reg == sesg_pkg::SESG_OPC_WAIT)
    else $error("marker did not wait");

  // pending work done sets bit 0 and frees the marker
  a_opc_finish: assert property (@(posedge clk) disable iff (!rst_n)
    (opc_reg == sesg_pkg::SESG_OPC_WAIT && !ops_pending)
    |=> latch_reg[0] && opc_reg == sesg_pkg::SESG_OPC_IDLE)
    else $error("deferred completion missing");

  // clear-status drops a waiting marker
  a_opc_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    clear_status |=> opc_reg == sesg_pkg::SESG_OPC_IDLE)
    else $error("marker survived clear");

  // an event in the read cycle is kept
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_read && exec_error) |=> latch_reg[4])
    else $error("set lost to clear");

  // first edge after reset shows the power-up state; no disable, reset is the cause
  a_pon_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> latch_reg == sesg_pkg::LATCH_RESET && enable_reg == 8'h00)
    else $error("power-up state wrong");
endmodule

// ### sim/sesg_host.sv
/*
  Remote controller model: issues mask writes, queries and clear-status.
  Assumes the device answers a query with a one-cycle read_valid.
*/
`timescale 1ns/1ps
module sesg_host (
  input wire logic clk,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  output logic enable_write,
  output logic [7:0] enable_data,
  output logic latch_read,
  output logic enable_read,
  output logic clear_status,
  output logic after_terminator
);
  initial begin
    {enable_write, enable_data, latch_read, enable_read, clear_status, after_terminator} = '0;
  end
  // the mask parameter is always supplied
  task automatic write_mask(input logic [7:0] v);
    @(negedge clk);
    enable_write = 1'b1;
    enable_data = v;
    @(negedge clk);
    enable_write = 1'b0;
    enable_data = ~v; // stale value must not be reused
  endtask
  // bounded wait so a missing answer cannot hang
  task automatic query(input logic ev, output logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk);
    latch_read = ev;
    enable_read = !ev;
    @(negedge clk);
    latch_read = 1'b0;
    enable_read = 1'b0;
    v = 8'hXX;
    while (read_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (read_valid === 1'b1) v = read_data;
  endtask
  task automatic clear(input logic term);
    @(negedge clk);
    clear_status = 1'b1;
    after_terminator = term;
    @(negedge clk);
    clear_status = 1'b0;
  endtask
endmodule

// ### sim/tb_standard_event_status_group.sv
/*
  Self-checking bench for the event status group.
  Assumes sesg_top and the sesg_host controller model.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_standard_event_status_group;
  logic clk, rst_n, ops_pending, status_preset, summary, clear_others, clear_output_queue;
  logic [7:0] ev, read_data, v;
  logic read_valid, enable_write, latch_read, enable_read, clear_status, after_terminator;
  logic [7:0] enable_data;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] weight [8] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20};
  sesg_top i_sesg_top (.clk(clk), .rst_n(rst_n), .opc_cmd(ev[0]), .ops_pending(ops_pending),
    .query_empty_read(ev[1]), .query_interrupted(ev[2]), .query_deadlock(ev[3]),
    .selftest_fail(ev[4]), .cal_fail(ev[5]), .exec_error(ev[6]), .cmd_error(ev[7]),
    .enable_write(enable_write), .enable_data(enable_data), .latch_read(latch_read),
    .enable_read(enable_read), .clear_status(clear_status), .after_terminator(after_terminator),
    .status_preset(status_preset), .read_data(read_data), .read_valid(read_valid),
    .summary(summary), .clear_others(clear_others), .clear_output_queue(clear_output_queue));
  sesg_host i_sesg_host (.clk(clk), .read_data(read_data), .read_valid(read_valid),
    .enable_write(enable_write), .enable_data(enable_data), .latch_read(latch_read),
    .enable_read(enable_read), .clear_status(clear_status), .after_terminator(after_terminator));
  always #5 clk = ~clk;
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev = 8'h00;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_pon();
    i_sesg_host.query(1'b1, v);
    `CHK("pon", 8'h80, v)
    `CHK("valid", 1'b1, read_valid)
    i_sesg_host.query(1'b1, v);
    `CHK("pon read", 8'h00, v)
  endtask
  task automatic t_sources();
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      repeat (3) @(negedge clk);
      i_sesg_host.query(1'b1, v);
      `CHK("event", weight[i], v)
    end
  endtask
  task automatic t_opc();
    ops_pending = 1'b1;
    pulse(0);
    repeat (5) @(negedge clk);
    i_sesg_host.query(1'b1, v);
    `CHK("opc early", 8'h00, v)
    ops_pending = 1'b0;
    repeat (2) @(negedge clk);
    i_sesg_host.query(1'b1, v);
    `CHK("opc late", 8'h01, v)
  endtask
  task automatic t_summary();
    i_sesg_host.write_mask(8'h20);
    i_sesg_host.query(1'b0, v);
    `CHK("mask", 8'h20, v)
    pulse(6);
    repeat (2) @(negedge clk);
    `CHK("masked", 1'b0, summary)
    pulse(7);
    repeat (2) @(negedge clk);
    `CHK("enabled", 1'b1, summary)
    @(negedge clk) status_preset = 1'b1;
    @(negedge clk) status_preset = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("preset", 1'b1, summary)
    i_sesg_host.query(1'b1, v);
    repeat (2) @(negedge clk);
    `CHK("cleared", 1'b0, summary)
  endtask
  task automatic t_clear();
    pulse(4);
    i_sesg_host.clear(1'b1);
    `CHK("others", 1'b1, clear_others)
    `CHK("outq", 1'b1, clear_output_queue)
    i_sesg_host.query(1'b1, v);
    `CHK("latch", 8'h00, v)
    i_sesg_host.query(1'b0, v);
    `CHK("mask kept", 8'h20, v)
    i_sesg_host.clear(1'b0);
    `CHK("others2", 1'b1, clear_others)
    `CHK("no outq", 1'b0, clear_output_queue)
    @(negedge clk);
    ev[6] = 1'b1;
    i_sesg_host.latch_read = 1'b1;
    @(negedge clk);
    ev = 8'h00;
    i_sesg_host.latch_read = 1'b0;
    i_sesg_host.query(1'b1, v);
    `CHK("race", 8'h10, v)
  endtask
  initial begin
    #200us;
    n_errors++;
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ev = 8'h00;
    ops_pending = 1'b0;
    status_preset = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_pon();
    t_sources();
    t_opc();
    t_summary();
    t_clear();
    wrap_up();
  end
endmodule
